// file: cache_pkg.sv
// shared constants, command codes, state enums and carrier structs of the read-ahead cache
// assumes one clock domain; the host controller and the read channel are logic on that clock
package cache_pkg;

	// buffer sizing
	localparam int BUF_KB_SMALL         = 512;
	localparam int BUF_KB_LARGE         = 2048;
	localparam int WORK_KB              = 64;   // processor work area carved off the buffer
	localparam int SECTOR_BYTES         = 512;
	localparam int DATA_W               = 32;
	localparam int SECTOR_WORDS         = SECTOR_BYTES / (DATA_W / 8);
	localparam int WORD_W               = $clog2(SECTOR_WORDS);

	// prefetch amount after a miss or a non-sequential partial hit
	localparam int PREFETCH_SECTORS_DEF = 256;

	// command fields
	localparam int LBA_W                = 28;
	localparam int CNT_W                = 9;
	localparam logic [CNT_W-1:0] COUNT_OF_ZERO = 9'h100;  // a count field of zero means 256

	// reset values
	localparam logic CACHE_EN_RST       = 1'b1;
	localparam logic [LBA_W-1:0] LBA_RST = 28'h000_0000;

	typedef enum logic [3:0] {
		OP_READ_SECTORS,
		OP_READ_MULTIPLE,
		OP_READ_DMA,
		OP_READ_VERIFY,
		OP_WRITE_SECTORS,
		OP_WRITE_MULTIPLE,
		OP_WRITE_DMA,
		OP_CHECK_POWER,
		OP_SET_FEATURES,
		OP_OTHER
	} op_t;

	typedef enum logic {XF_IDLE, XF_BUSY} xfer_st_t;

	typedef enum logic [1:0] {ALT_IDLE, ALT_REWRITE, ALT_ASSIGN} alt_st_t;

	// command as decoded by the host controller
	typedef struct packed {
		op_t              op;
		logic [LBA_W-1:0] lba;
		logic [7:0]       count;
		logic             cache_off;  // set features: caching disabled
		logic             cache_on;   // set features: caching enabled
	} host_cmd_t;

	// media error events from the read/write channel
	typedef struct packed {
		logic             recov_ecc_raised;  // read error recovered only with stronger correction
		logic             wr_unrecov;        // write error that retries did not recover
		logic             rewrite_done;      // rewrite and reread of a sector finished
		logic             reread_err;        // reread after rewrite still failed
		logic [LBA_W-1:0] lba;
	} media_event_t;

endpackage

// file: buf_mem.sv
// single-port-write, single-port-read buffer memory with registered read data
// assumes both ports on one clock; read data appear one cycle after rd_en
`timescale 1ns/1ps
module buf_mem #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 1024,
	parameter int AW    = $clog2(DEPTH)
) (
	input  wire logic             sys_clk,
	input  wire logic             wr_en,
	input  wire logic [AW-1:0]    wr_addr,
	input  wire logic [WIDTH-1:0] wr_data,
	input  wire logic             rd_en,
	input  wire logic [AW-1:0]    rd_addr,
	output logic      [WIDTH-1:0] rd_data
);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [WIDTH-1:0] rd_data_q;

	////////////////////////////////////////////////////////////////////////////////
	// storage and registered read
	always_ff @(posedge sys_clk) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
		if (rd_en) begin
			rd_data_q <= mem[rd_addr];
		end
	end

	assign rd_data = rd_data_q;

endmodule // buf_mem

// file: disk_read_ahead_cache.sv
// read-ahead cache manager: lookup, prefetch, invalidation and alternate assignment triggers
// assumes host controller and read channel on sys_clk; synchronous active-high rst
`timescale 1ns/1ps

// Function
// - ecc-boosted read recovery starts alternate assignment
// - rewrite and reread first; clean reread skips
// - unrecovered write error starts alternate assignment
// - after medium read, prefetch following blocks
// - buffer minus work area forms read cache
// - only three read commands trigger read-ahead
// - serve full or lead-sector partial hits
// - lookup for reads; verify only if sequential
// - caching disabled means no hits, no caching
// - only stored sectors count as cached
// - data sent by sequential hits is dropped
// - other commands, except writes and check power, invalidate all cached data
// - command ending in error invalidates cache
// - resets and cache-off invalidate cache
// - miss puts both pointers after last segment
// - after miss, prefetch a set amount
// - sequential read fills free buffer space
// - sequential hit sends buffered data
// - prefetch into space freed by transfer
// - full hit points host pointer, keeps cache
// - full hit triggers no read-ahead
// - full hit leaves running prefetch alone
// - partial hit: host at hit, disk past
module disk_read_ahead_cache
	import cache_pkg::*;
#(
	parameter int BUF_KB           = BUF_KB_SMALL,
	parameter int CACHE_SECTORS    = (BUF_KB - WORK_KB) * 1024 / SECTOR_BYTES,
	parameter int PREFETCH_SECTORS = PREFETCH_SECTORS_DEF,
	localparam int SLOT_W          = $clog2(CACHE_SECTORS),
	localparam int VW              = SLOT_W + 1
) (
	input  wire logic              sys_clk,
	input  wire logic              rst,
	input  wire logic              soft_reset,
	input  wire logic              cmd_valid,
	input  wire host_cmd_t         cmd,
	output logic                   cmd_ready,
	input  wire logic              cmd_err,
	output logic                   cmd_done,
	output logic      [DATA_W-1:0] host_data,
	output logic                   host_data_valid,
	input  wire logic              host_ready,
	output logic                   disk_req_valid,
	output logic      [LBA_W-1:0]  disk_req_lba,
	input  wire logic              disk_req_ready,
	input  wire logic              disk_data_valid,
	input  wire logic [DATA_W-1:0] disk_data,
	input  wire media_event_t      media_evt,
	output logic                   rewrite_req,
	output logic                   alt_assign,
	output logic      [LBA_W-1:0]  alt_lba,
	output logic                   cache_enabled,
	output logic      [SLOT_W-1:0] host_transfer_pointer,
	output logic      [SLOT_W-1:0] disk_read_pointer,
	output logic      [VW-1:0]     cached_sectors
);

	localparam int AW     = SLOT_W + WORD_W;
	localparam int DEPTH  = CACHE_SECTORS * SECTOR_WORDS;
	localparam int TODO_W = $clog2(CACHE_SECTORS + 256 + PREFETCH_SECTORS) + 1;
	localparam logic [VW:0]         N_S       = (VW + 1)'(CACHE_SECTORS);
	localparam logic [WORD_W-1:0]   WORD_LAST = WORD_W'(SECTOR_WORDS - 1);
	localparam logic [TODO_W-1:0]   TODO_FILL = TODO_W'(CACHE_SECTORS);
	localparam logic [TODO_W-1:0]   TODO_PREF = TODO_W'(PREFETCH_SECTORS);

	// slot a plus b around the ring, b no larger than the ring
	function automatic logic [SLOT_W-1:0] wrap_add(input logic [SLOT_W-1:0] a,
			input logic [VW-1:0] b);
		logic [VW:0] s;
		s = {2'b00, a} + {1'b0, b};
		if (s >= N_S) begin
			s = s - N_S;
		end
		return s[SLOT_W-1:0];
	endfunction

	// sectors from tail t forward to slot a
	function automatic logic [VW-1:0] ring_dist(input logic [SLOT_W-1:0] a,
			input logic [SLOT_W-1:0] t);
		logic [VW:0] d;
		d = {2'b00, a} + N_S - {2'b00, t};
		if (d >= N_S) begin
			d = d - N_S;
		end
		return d[VW-1:0];
	endfunction

	function automatic logic [AW-1:0] mem_addr(input logic [SLOT_W-1:0] slot,
			input logic [WORD_W-1:0] word);
		return {slot, word};
	endfunction

	xfer_st_t          cst_q, cst_d;
	logic              cache_en_q, cache_en_d;
	logic [SLOT_W-1:0] tail_q, tail_d, hap_q, hap_d, dap_q, dap_d;
	logic [VW-1:0]     valid_q, valid_d;
	logic [LBA_W-1:0]  base_q, base_d, next_lba_q, next_lba_d;
	logic              consume_q, consume_d, verify_q, verify_d;
	logic [CNT_W-1:0]  sec_left_q, sec_left_d;
	logic [WORD_W-1:0] word_q, word_d, disk_word_q, disk_word_d;
	logic              pend_q, pend_d, out_valid_q, out_valid_d, done_q, done_d;
	logic [DATA_W-1:0] host_data_q, host_data_d;
	logic [TODO_W-1:0] todo_q, todo_d;
	logic              busy_q, busy_d, drop_q, drop_d, ready_q, ready_d;
	logic              req_valid_q, req_valid_d;
	logic [LBA_W-1:0]  req_lba_q, req_lba_d;
	logic              sec_cmpl, wr_en, rd_en, outstanding, accept, inval, abort;
	logic              seq, read3, is_read, lookup, hit, full;
	logic [LBA_W-1:0]  off_l;
	logic [CNT_W-1:0]  cnt9;
	logic [DATA_W-1:0] rd_data;

	////////////////////////////////////////////////////////////////////////////////
	// read-cache area of the data buffer
	buf_mem #(.WIDTH(DATA_W), .DEPTH(DEPTH), .AW(AW)) u_mem (
		.sys_clk (sys_clk),
		.wr_en   (wr_en),
		.wr_addr (mem_addr(dap_q, disk_word_q)),
		.wr_data (disk_data),
		.rd_en   (rd_en),
		.rd_addr (mem_addr(hap_q, word_q)),
		.rd_data (rd_data)
	);

	////////////////////////////////////////////////////////////////////////////////
	// cache bookkeeping, disk fetch and host transfer: next values
	always_comb begin
		cst_d       = cst_q;
		cache_en_d  = cache_en_q;
		tail_d      = tail_q;
		hap_d       = hap_q;
		dap_d       = dap_q;
		valid_d     = valid_q;
		base_d      = base_q;
		next_lba_d  = next_lba_q;
		consume_d   = consume_q;
		verify_d    = verify_q;
		sec_left_d  = sec_left_q;
		word_d      = word_q;
		disk_word_d = disk_word_q;
		host_data_d = host_data_q;
		todo_d      = todo_q;
		busy_d      = busy_q;
		drop_d      = drop_q;
		req_valid_d = req_valid_q;
		req_lba_d   = req_lba_q;
		done_d      = 1'b0;
		inval       = 1'b0;
		abort       = cmd_err || soft_reset;
		accept      = cmd_valid && ready_q;
		outstanding = req_valid_q || busy_q;
		sec_cmpl    = disk_data_valid && busy_q && (disk_word_q == WORD_LAST);
		wr_en       = disk_data_valid && busy_q && !drop_q;
		cnt9        = (cmd.count == 8'h00) ? COUNT_OF_ZERO : {1'b0, cmd.count};
		seq         = (cmd.lba == next_lba_q);
		read3       = (cmd.op == OP_READ_SECTORS) || (cmd.op == OP_READ_MULTIPLE)
			|| (cmd.op == OP_READ_DMA);
		is_read     = read3 || (cmd.op == OP_READ_VERIFY);
		lookup      = cache_en_q && (read3 || ((cmd.op == OP_READ_VERIFY) && seq));
		off_l       = cmd.lba - base_q;
		hit         = lookup && (cmd.lba >= base_q) && (off_l < LBA_W'(valid_q));
		full        = hit && ((off_l + LBA_W'(cnt9)) <= LBA_W'(valid_q));

		// disk side: request accepted, then one sector of words lands at the disk pointer
		if (req_valid_q && disk_req_ready) begin
			req_valid_d = 1'b0;
			busy_d      = 1'b1;
		end
		if (disk_data_valid && busy_q) begin
			disk_word_d = disk_word_q + 1'b1;
		end
		if (sec_cmpl) begin
			busy_d = 1'b0;
			drop_d = 1'b0;
			if (!drop_q) begin
				valid_d = valid_q + 1'b1;
				dap_d   = wrap_add(dap_q, VW'(1));
				if (todo_q != '0) begin
					todo_d = todo_q - 1'b1;
				end
			end
		end

		// host side: one word in flight, read only from stored sectors
		rd_en  = (cst_q == XF_BUSY) && (sec_left_q != '0) && !pend_q
			&& (!out_valid_q || host_ready) && (ring_dist(hap_q, tail_q) < valid_q);
		pend_d = rd_en;
		out_valid_d = out_valid_q && !host_ready;
		if (pend_q && !verify_q && (cst_q == XF_BUSY)) begin
			out_valid_d = 1'b1;
			host_data_d = rd_data;
		end
		if (rd_en) begin
			word_d = word_q + 1'b1;
			if (word_q == WORD_LAST) begin
				sec_left_d = sec_left_q - 1'b1;
				hap_d      = wrap_add(hap_q, VW'(1));
				if (consume_q) begin
					tail_d  = wrap_add(tail_q, VW'(1));
					base_d  = base_q + 1'b1;
					valid_d = valid_d - 1'b1;
				end
			end
		end
		if ((cst_q == XF_BUSY) && (sec_left_q == '0) && !pend_q && !out_valid_q) begin
			cst_d  = XF_IDLE;
			done_d = 1'b1;
			inval  = !cache_en_q;
		end

		// prefetch engine: one sector request at a time while space remains
		if (!outstanding && (todo_q != '0) && (valid_q < N_S[VW-1:0]) && !accept) begin
			req_valid_d = 1'b1;
			req_lba_d   = base_q + LBA_W'(valid_q);
		end

		// command acceptance and lookup
		if (accept) begin
			if (is_read) begin
				cst_d      = XF_BUSY;
				sec_left_d = cnt9;
				word_d     = '0;
				verify_d   = (cmd.op == OP_READ_VERIFY);
				consume_d  = hit && seq;
				next_lba_d = cmd.lba + LBA_W'(cnt9);
				if (hit) begin
					hap_d = wrap_add(tail_q, off_l[VW-1:0]);
					// missing sectors, then a whole ring more if sequential or the set prefetch amount if not; verify adds none
					if (!full) begin
						todo_d = TODO_W'(off_l + LBA_W'(cnt9) - LBA_W'(valid_q))
							+ (!read3 ? '0 : (seq ? TODO_FILL : TODO_PREF));
					end
				end else begin
					tail_d  = dap_d;
					hap_d   = dap_d;
					valid_d = '0;
					base_d  = cmd.lba;
					drop_d  = outstanding && !sec_cmpl;
					todo_d  = TODO_W'(cnt9) + ((read3 && cache_en_q) ? TODO_PREF : '0);
				end
				if (hit && seq && (off_l != '0)) begin
					tail_d  = hap_d;
					base_d  = cmd.lba;
					valid_d = valid_d - off_l[VW-1:0];
				end
			end else begin
				done_d = 1'b1;
				if ((cmd.op != OP_WRITE_SECTORS) && (cmd.op != OP_WRITE_MULTIPLE)
						&& (cmd.op != OP_WRITE_DMA) && (cmd.op != OP_CHECK_POWER)) begin
					inval = 1'b1;
				end
				if ((cmd.op == OP_SET_FEATURES) && cmd.cache_off) begin
					cache_en_d = 1'b0;
				end else if ((cmd.op == OP_SET_FEATURES) && cmd.cache_on) begin
					cache_en_d = 1'b1;
				end
			end
		end

		// invalidation drops every cached sector and the running prefetch
		if (inval || abort) begin
			tail_d  = dap_d;
			hap_d   = dap_d;
			valid_d = '0;
			todo_d  = '0;
			drop_d  = outstanding && !sec_cmpl;
		end
		if (abort) begin
			cst_d       = XF_IDLE;
			sec_left_d  = '0;
			out_valid_d = 1'b0;
			done_d      = 1'b0;
		end
		ready_d = (cst_d == XF_IDLE);
	end

	////////////////////////////////////////////////////////////////////////////////
	// cache bookkeeping registers
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			cst_q       <= XF_IDLE;
			cache_en_q  <= CACHE_EN_RST;
			tail_q      <= '0;
			hap_q       <= '0;
			dap_q       <= '0;
			valid_q     <= '0;
			base_q      <= LBA_RST;
			next_lba_q  <= LBA_RST;
			consume_q   <= 1'b0;
			verify_q    <= 1'b0;
			sec_left_q  <= '0;
			word_q      <= '0;
			disk_word_q <= '0;
			host_data_q <= '0;
			todo_q      <= '0;
			busy_q      <= 1'b0;
			drop_q      <= 1'b0;
			req_valid_q <= 1'b0;
			req_lba_q   <= LBA_RST;
			pend_q      <= 1'b0;
			out_valid_q <= 1'b0;
			done_q      <= 1'b0;
			ready_q     <= 1'b0;
		end else begin
			cst_q       <= cst_d;
			cache_en_q  <= cache_en_d;
			tail_q      <= tail_d;
			hap_q       <= hap_d;
			dap_q       <= dap_d;
			valid_q     <= valid_d;
			base_q      <= base_d;
			next_lba_q  <= next_lba_d;
			consume_q   <= consume_d;
			verify_q    <= verify_d;
			sec_left_q  <= sec_left_d;
			word_q      <= word_d;
			disk_word_q <= disk_word_d;
			host_data_q <= host_data_d;
			todo_q      <= todo_d;
			busy_q      <= busy_d;
			drop_q      <= drop_d;
			req_valid_q <= req_valid_d;
			req_lba_q   <= req_lba_d;
			pend_q      <= pend_d;
			out_valid_q <= out_valid_d;
			done_q      <= done_d;
			ready_q     <= ready_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// automatic alternate assignment trigger
	alt_st_t          alt_q, alt_d;
	logic             rewrite_q, rewrite_d, assign_q, assign_d;
	logic [LBA_W-1:0] alt_lba_q, alt_lba_d;

	always_comb begin
		alt_d     = alt_q;
		alt_lba_d = alt_lba_q;
		rewrite_d = 1'b0;
		assign_d  = 1'b0;
		case (alt_q)
			ALT_IDLE: begin
				if (media_evt.wr_unrecov) begin
					alt_lba_d = media_evt.lba;
					alt_d     = ALT_ASSIGN;
				end else if (media_evt.recov_ecc_raised) begin
					alt_lba_d = media_evt.lba;
					rewrite_d = 1'b1;
					alt_d     = ALT_REWRITE;
				end
			end
			ALT_REWRITE: begin
				if (media_evt.rewrite_done) begin
					alt_d = media_evt.reread_err ? ALT_ASSIGN : ALT_IDLE;
				end
			end
			ALT_ASSIGN: begin
				assign_d = 1'b1;
				alt_d    = ALT_IDLE;
			end
			default: alt_d = ALT_IDLE;
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			alt_q     <= ALT_IDLE;
			alt_lba_q <= LBA_RST;
			rewrite_q <= 1'b0;
			assign_q  <= 1'b0;
		end else begin
			alt_q     <= alt_d;
			alt_lba_q <= alt_lba_d;
			rewrite_q <= rewrite_d;
			assign_q  <= assign_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// outputs, all from registers
	assign cmd_ready             = ready_q;
	assign cmd_done              = done_q;
	assign host_data             = host_data_q;
	assign host_data_valid       = out_valid_q;
	assign disk_req_valid        = req_valid_q;
	assign disk_req_lba          = req_lba_q;
	assign rewrite_req           = rewrite_q;
	assign alt_assign            = assign_q;
	assign alt_lba               = alt_lba_q;
	assign cache_enabled         = cache_en_q;
	assign host_transfer_pointer = hap_q;
	assign disk_read_pointer     = dap_q;
	assign cached_sectors        = valid_q;

endmodule // disk_read_ahead_cache

// file: cache_monitor.sv
// port checker of the read-ahead cache manager
// assumes one sys_clk domain and a synchronous active-high rst
`timescale 1ns/1ps
module cache_monitor
	import cache_pkg::*;
#(
	parameter int CACHE_SECTORS = 896,
	localparam int SLOT_W       = $clog2(CACHE_SECTORS),
	localparam int VW           = SLOT_W + 1
) (
	input wire logic             sys_clk,
	input wire logic             rst,
	input wire logic             soft_reset,
	input wire logic             cmd_valid,
	input wire host_cmd_t        cmd,
	input wire logic             cmd_ready,
	input wire logic             cmd_err,
	input wire logic             cmd_done,
	input wire logic [DATA_W-1:0] host_data,
	input wire logic             host_data_valid,
	input wire logic             host_ready,
	input wire logic             disk_req_valid,
	input wire logic [LBA_W-1:0] disk_req_lba,
	input wire logic             disk_req_ready,
	input wire media_event_t     media_evt,
	input wire logic             rewrite_req,
	input wire logic             alt_assign,
	input wire logic [LBA_W-1:0] alt_lba,
	input wire logic             cache_enabled,
	input wire logic [VW-1:0]    cached_sectors
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);
	logic alt_pend_q, alt_pend_d;
	////////////////////////////////////////////////////////////////////////////
	// remembers a rewrite that still waits for its reread result
	always_comb begin
		alt_pend_d = alt_pend_q;
		if (rewrite_req) alt_pend_d = 1'b1;
		if (media_evt.rewrite_done) alt_pend_d = 1'b0;
	end
	always_ff @(posedge sys_clk) begin
		alt_pend_q <= rst ? 1'b0 : alt_pend_d;
	end
	////////////////////////////////////////////////////////////////////////////
	sequence s_accept;
		cmd_valid && cmd_ready;
	endsequence
	sequence s_alt_idle;
		!alt_pend_q && !rewrite_req && !alt_assign;
	endsequence
	sequence s_clear;
		cached_sectors == '0;
	endsequence
	AST_RESET_STATE: assert property ($fell(rst) |-> !cmd_ready && cache_enabled)
		else $error("state after reset wrong");
	AST_HOST_HOLD: assert property (host_data_valid && !host_ready && !cmd_err && !soft_reset
		|=> host_data_valid && $stable(host_data)) else $error("host word dropped");
	AST_DISK_HOLD: assert property (disk_req_valid && !disk_req_ready && !cmd_err && !soft_reset
		|=> disk_req_valid && $stable(disk_req_lba)) else $error("disk request dropped");
	AST_REWRITE: assert property (media_evt.recov_ecc_raised && !media_evt.wr_unrecov
		and s_alt_idle |=> rewrite_req) else $error("no rewrite request");
	AST_REREAD_ALT: assert property (media_evt.rewrite_done && media_evt.reread_err
		&& alt_pend_q |-> ##2 alt_assign) else $error("no assignment after bad reread");
	AST_CLEAN_SKIP: assert property (media_evt.rewrite_done && !media_evt.reread_err
		&& alt_pend_q |=> !alt_assign [*3]) else $error("assignment after clean reread");
	AST_WRITE_ALT: assert property (media_evt.wr_unrecov and s_alt_idle
		|-> ##2 alt_assign && alt_lba == $past(media_evt.lba, 2)) else $error("no write assignment");
	AST_KEEP_DONE: assert property (s_accept ##0 !cmd_err
		&& cmd.op inside {[OP_WRITE_SECTORS:OP_CHECK_POWER]} |=> cmd_done && cmd_ready)
		else $error("non-read command not finished");
	AST_ERR_CLEAR: assert property (cmd_err || soft_reset |-> ##[1:2] s_clear)
		else $error("cache kept after error");
	AST_FEAT_OFF: assert property (s_accept ##0 cmd.op == OP_SET_FEATURES && cmd.cache_off
		|-> ##[1:2] !cache_enabled ##0 s_clear) else $error("cache kept after disable");
	AST_SLOTS: assert property (cached_sectors <= VW'(CACHE_SECTORS))
		else $error("cache overfilled");
endmodule // cache_monitor

bind disk_read_ahead_cache cache_monitor #(.CACHE_SECTORS(CACHE_SECTORS)) mon (
	.sys_clk, .rst, .soft_reset, .cmd_valid, .cmd, .cmd_ready, .cmd_err, .cmd_done,
	.host_data, .host_data_valid, .host_ready, .disk_req_valid, .disk_req_lba,
	.disk_req_ready, .media_evt, .rewrite_req, .alt_assign, .alt_lba, .cache_enabled,
	.cached_sectors
);

// file: read_channel_model.sv
// read channel stand-in: takes one sector request, then streams its 128 words
// assumes sys_clk domain; slow inserts stalls and refuses requests
`timescale 1ns/1ps
module read_channel_model
	import cache_pkg::*;
(
	input  wire logic              sys_clk,
	input  wire logic              rst,
	input  wire logic              slow,
	input  wire logic              disk_req_valid,
	input  wire logic [LBA_W-1:0]  disk_req_lba,
	output logic                   disk_req_ready,
	output logic                   disk_data_valid,
	output logic      [DATA_W-1:0] disk_data,
	output logic                   busy
);
	logic [LBA_W-1:0] lba_q;
	int               cnt_q;
	// one sector outstanding; idle data line shows the inverse of its last value
	always @(posedge sys_clk) begin
		if (rst) begin
			disk_req_ready <= 1'b0;
			disk_data_valid <= 1'b0;
			disk_data <= '0;
			busy <= 1'b0;
		end else if (!busy || slow) begin
			disk_data_valid <= 1'b0;
			disk_data <= ~disk_data;
			disk_req_ready <= !busy && disk_req_valid && !disk_req_ready && !slow;
			if (!busy && disk_req_valid && disk_req_ready) begin
				disk_req_ready <= 1'b0;
				busy <= 1'b1;
				lba_q <= disk_req_lba;
				cnt_q <= 0;
			end
		end else begin
			disk_data_valid <= 1'b1;
			disk_data <= {lba_q[24:0], cnt_q[6:0]};
			cnt_q <= cnt_q + 1;
			busy <= cnt_q != 127;
		end
	end
endmodule // read_channel_model

// file: tb.sv
// self-checking bench of the read-ahead cache manager
// assumes the package, design, channel model and checker compile first
`timescale 1ns/1ps
`define CHECK(got, want, msg) begin tests_run++; if ((got) !== (want)) begin n_errors++; \
	$display("wrong value at %0t: %s", $time, msg); end end
module tb;
	import cache_pkg::*;
	localparam int CS = 8;
	localparam int PF = 2;
	logic              sys_clk = 1'b0;
	logic              rst = 1'b1;
	logic              soft_reset = 1'b0;
	logic              cmd_valid = 1'b0;
	logic              cmd_err = 1'b0;
	logic              host_ready = 1'b0;
	logic              slow = 1'b0;
	host_cmd_t         cmd = '0;
	media_event_t      media_evt = '0;
	logic              cmd_ready, cmd_done, host_data_valid, disk_req_valid, disk_req_ready;
	logic              disk_data_valid, chan_busy, rewrite_req, alt_assign, cache_enabled;
	logic [DATA_W-1:0] host_data, disk_data;
	logic [LBA_W-1:0]  disk_req_lba, alt_lba;
	logic [3:0]        cached_sectors;
	logic [31:0]       lfsr = 32'h0000_bcbb;
	logic [DATA_W-1:0] exp_q[$];
	int                n_errors = 0, tests_run = 0, n_req = 0, n_alt = 0, n_rw = 0;
	int                next_lba = -1, r0;
	logic [3:0]        c0;
	////////////////////////////////////////////////////////////////////////////
	always #2 sys_clk = ~sys_clk;
	disk_read_ahead_cache #(.CACHE_SECTORS(CS), .PREFETCH_SECTORS(PF)) DUT (.sys_clk, .rst,
		.soft_reset, .cmd_valid, .cmd, .cmd_ready, .cmd_err, .cmd_done, .host_data,
		.host_data_valid, .host_ready, .disk_req_valid, .disk_req_lba, .disk_req_ready,
		.disk_data_valid, .disk_data, .media_evt, .rewrite_req, .alt_assign, .alt_lba,
		.cache_enabled, .host_transfer_pointer(), .disk_read_pointer(), .cached_sectors);
	read_channel_model chan (.sys_clk, .rst, .slow, .disk_req_valid, .disk_req_lba,
		.disk_req_ready, .disk_data_valid, .disk_data, .busy(chan_busy));
	////////////////////////////////////////////////////////////////////////////
	function automatic logic [DATA_W-1:0] word_of(input int lba, input int w);
		return {lba[24:0], w[6:0]};
	endfunction
	task automatic stop_test;
		if (n_errors == 0 && tests_run > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic issue(input op_t op, input int lba, input int n, input logic [1:0] ctl);
		@(negedge sys_clk);
		cmd_valid <= 1'b1;
		cmd <= '{op: op, lba: LBA_W'(lba), count: 8'(n), cache_off: ctl[0], cache_on: ctl[1]};
		while (cmd_ready !== 1'b1) @(negedge sys_clk);
		@(negedge sys_clk);
		cmd_valid <= 1'b0;
	endtask
	task automatic rd(input op_t op, input int lba, input int n, input logic words);
		for (int s = 0; s < n * 128; s++) if (words) exp_q.push_back(word_of(lba + s / 128, s % 128));
		issue(op, lba, n, 2'b00);
		for (int t = 0; t < 9000 && cmd_done !== 1'b1; t++) @(negedge sys_clk);
		`CHECK(exp_q.size(), 0, "host words missing")
	endtask
	task automatic settle;
		int q = 0;
		for (int t = 0; t < 9000 && q < 4; t++) begin
			@(negedge sys_clk);
			q = (disk_req_valid || chan_busy) ? 0 : q + 1;
		end
	endtask
	task automatic media(input int kind, input logic [LBA_W-1:0] a);
		int a0 = n_alt;
		r0 = n_rw;
		@(negedge sys_clk);
		media_evt <= '{kind < 2, kind == 2, 1'b0, 1'b0, a};
		@(negedge sys_clk);
		media_evt <= '0;
		repeat (3) @(negedge sys_clk);
		if (kind < 2) media_evt <= '{1'b0, 1'b0, 1'b1, kind == 1, a};
		@(negedge sys_clk);
		media_evt <= '0;
		repeat (6) @(negedge sys_clk);
		`CHECK(n_rw - r0, int'(kind < 2), "rewrite count")
		`CHECK(n_alt - a0, int'(kind > 0), "assignment count")
		if (kind > 0) `CHECK(alt_lba, a, "assignment sector")
	endtask
	////////////////////////////////////////////////////////////////////////////
	// random host stalls and channel pace, driven off the sampling edge
	always @(negedge sys_clk) begin
		lfsr <= {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
		host_ready <= lfsr[0] | lfsr[1];
		slow <= lfsr[2] & lfsr[3];
	end
	// compares every host word with the model and counts disk requests and pulses
	always @(posedge sys_clk) begin
		if (host_data_valid && host_ready) begin
			if (exp_q.size() == 0) `CHECK(1'b1, 1'b0, "unexpected host word")
			else `CHECK(host_data, exp_q.pop_front(), "host word")
		end
		if (disk_req_valid && disk_req_ready) begin
			n_req++;
			if (next_lba >= 0) `CHECK(disk_req_lba, LBA_W'(next_lba++), "disk sector")
		end
		if (alt_assign) n_alt++;
		if (rewrite_req) n_rw++;
	end
	initial begin
		repeat (60000) @(posedge sys_clk);
		n_errors++;
		stop_test();
	end
	////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (20) @(negedge sys_clk);
		rst <= 1'b0;
		repeat (2) @(negedge sys_clk);
		`CHECK(cached_sectors, 4'h0, "empty after reset")
		// miss, then a set amount of read-ahead
		next_lba = 100;
		rd(OP_READ_SECTORS, 100, 2, 1'b1);
		settle();
		`CHECK(n_req, 2 + PF, "miss requests")
		`CHECK(cached_sectors, 4'(2 + PF), "sent data kept")
		// non-sequential full hit: no disk access, cache kept
		rd(OP_READ_MULTIPLE, 100, 1, 1'b1);
		settle();
		`CHECK(n_req, 2 + PF, "full hit requests")
		`CHECK(cached_sectors, 4'(2 + PF), "full hit keeps")
		// sequential hit fills the whole free space
		rd(OP_READ_DMA, 101, 4, 1'b1);
		settle();
		`CHECK(cached_sectors, 4'(CS), "sequential fill")
		// sector delivered by the sequential hit is gone
		r0 = n_req;
		next_lba = 101;
		rd(OP_READ_SECTORS, 101, 1, 1'b1);
		settle();
		`CHECK(n_req - r0, 1 + PF, "delivered data dropped")
		// partial hit: only missing sectors and read-ahead come from the medium
		r0 = n_req;
		next_lba = 104;
		rd(OP_READ_SECTORS, 103, 3, 1'b1);
		settle();
		`CHECK(n_req - r0, 2 + PF, "partial hit requests")
		next_lba = -1;
		rd(OP_READ_VERIFY, 500 + int'(lfsr[7:0]), 1, 1'b0);
		settle();
		// commands on the keep list leave the cache alone, others clear it
		c0 = cached_sectors;
		for (int i = 4; i < 8; i++) begin
			rd(op_t'(i), 0, 1, 1'b0);
			`CHECK(cached_sectors, c0, "kept by command")
		end
		rd(OP_OTHER, 0, 1, 1'b0);
		@(negedge sys_clk);
		`CHECK(cached_sectors, 4'h0, "cleared by command")
		// caching off: no read-ahead and nothing cached
		issue(OP_SET_FEATURES, 0, 0, 2'b01);
		repeat (2) @(negedge sys_clk);
		`CHECK(cache_enabled, 1'b0, "cache off")
		r0 = n_req;
		rd(OP_READ_DMA, 200, 2, 1'b1);
		settle();
		`CHECK(n_req - r0, 2, "no read-ahead when off")
		`CHECK(cached_sectors, 4'h0, "nothing cached when off")
		issue(OP_SET_FEATURES, 0, 0, 2'b10);
		// error in mid transfer, then a soft reset, both clear the cache
		for (int k = 0; k < 2; k++) begin
			rd(OP_READ_SECTORS, 300 + 10 * k, 1, 1'b1);
			for (int s = 0; s < 256; s++) exp_q.push_back(word_of(310 + 10 * k + s / 128, s % 128));
			issue(OP_READ_SECTORS, 310 + 10 * k, 2, 2'b00);
			repeat (200) @(negedge sys_clk);
			if (k == 0) cmd_err <= 1'b1;
			else soft_reset <= 1'b1;
			@(negedge sys_clk);
			cmd_err <= 1'b0;
			soft_reset <= 1'b0;
			exp_q.delete();
			repeat (2) @(negedge sys_clk);
			`CHECK(cached_sectors, 4'h0, "cleared by abort")
			settle();
		end
		// alternate assignment triggers
		for (int k = 0; k < 3; k++) media(k, LBA_W'(lfsr[19:0]));
		stop_test();
	end
endmodule // tb
